// ### rxc_pkg.sv
package rxc_pkg;
	// Serial frame
	localparam int FRAME_BITS = 16;
	localparam int READ_MIN_BITS = 8;
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WRITE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;
	localparam logic [3:0] CMD_MRESET = 4'h3;

	// Register offsets
	localparam logic [3:0] ADDR_POWER = 4'h0;
	localparam logic [3:0] ADDR_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_DIVISOR = 4'h3;
	localparam logic [3:0] ADDR_SLEEP_HI = 4'h4;
	localparam logic [3:0] ADDR_SLEEP_LO = 4'h5;
	localparam logic [3:0] ADDR_HOST_WAKE = 4'h6;
	localparam logic [3:0] ADDR_SETTLE_HI = 4'h7;
	localparam logic [3:0] ADDR_SETTLE_LO = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'h9;
	localparam logic [3:0] ADDR_DWELL = 4'ha;

	// Field positions
	localparam int CFG_DRX = 0;
	localparam int CFG_PS_LO = 1;
	localparam int CFG_FSK_PREC = 5;
	localparam int CTL_FSK_CAL = 0;
	localparam int CTL_POLL_CAL = 1;
	localparam int PWR_FSK_BB = 4;
	localparam int ST_LOCK = 7;
	localparam int ST_AGC = 6;
	localparam int ST_CLK_ALIVE = 5;
	localparam int ST_POLL_DONE = 1;
	localparam int ST_FSK_DONE = 0;
	localparam int DWELL_BITS = 5;

	// Values after reset
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h40;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DWELL = 8'h0d;

	// Timing, in ticks of the 100 kHz reference
	localparam int REF_HZ = 100000;
	localparam int HOST_WAKE_UNIT_US = 120;
	localparam int HOST_WAKE_TICKS = HOST_WAKE_UNIT_US * REF_HZ / 1000000;
	localparam int SLEEP_BASE_0 = 12;
	localparam int SLEEP_BASE_1 = 48;
	localparam int SLEEP_BASE_2 = 192;
	localparam int SLEEP_BASE_3 = 768;
	localparam int POLL_CAL_TICKS = 256;
	localparam int FSK_CAL_FAST_TICKS = 64;
	localparam int FSK_CAL_FULL_TICKS = 512;
endpackage

// ### rxc_cal_engine.sv
`timescale 1ns/1ps
module rxc_cal_engine #(
	parameter int SHORT_TICKS = 64,
	parameter int LONG_TICKS = 512
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic long_sel,
	input wire logic ref_tick,
	output logic busy,
	output logic done
);
	logic [15:0] count;
	logic [15:0] target;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy <= 1'b0;
			done <= 1'b0;
			count <= 16'h0000;
			target <= 16'h0000;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				// Done blocks a restart while the start bit is being cleared
				if (run && !done) begin
					busy <= 1'b1;
					count <= 16'h0000;
					target <= long_sel ? 16'(LONG_TICKS) : 16'(SHORT_TICKS);
				end
			end else if (ref_tick) begin
				if (count + 16'h0001 >= target) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count <= count + 16'h0001;
			end
		end
	end
endmodule

// ### rxc_core.sv
`timescale 1ns/1ps
module rxc_core (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_drive_n,
	input wire logic agc_above_threshold,
	input wire logic pll_lock,
	input wire logic crystal_alive,
	output logic [7:0] power_enables,
	output logic [7:0] device_configuration,
	output logic [7:0] calibration_and_tracking_control,
	output logic low_noise_amplifier_high_gain,
	output logic image_reject_ref,
	output logic rf_sections_on,
	output logic peak_detectors_on,
	output logic data_outputs_on
);
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_SLEEP = 3'b001,
		SEQ_HOST_WAKE = 3'b010,
		SEQ_SETTLE = 3'b011,
		SEQ_ACTIVE = 3'b100
	} rxc_seq_e;

	logic [2:0] cs_sync, sclk_sync, sdl_sync, agc_sync;
	logic [1:0] lock_sync, alive_sync;
	logic [7:0] crystal_divisor, sleep_interval_high, sleep_interval_low, host_wake_interval;
	logic [7:0] rf_settle_interval_high, rf_settle_interval_low, gain_hold_duration;
	logic poll_timer_cal_complete, fsk_cal_complete;
	logic mreset_hold, soft_rst;
	logic [15:0] shift_in;
	logic [4:0] bit_count;
	logic read_pending, read_active;
	logic [7:0] shift_out;
	logic [7:0] div_count;
	logic ref_tick;
	logic [31:0] dwell_count;
	logic poll_busy, poll_done, fsk_busy, fsk_done;
	logic auto_cal;
	rxc_seq_e seq_state;
	logic [15:0] unit_count, base_count, seq_target, base_target;
	logic host_held, seq_drive_low;
	logic [2:0] own_pull_hist;
	logic cs_n_s, sclk_s, sdl_s, agc_s, cs_rise, cs_fall, sclk_rise, sclk_fall;
	logic [3:0] frame_cmd, frame_addr;
	logic [7:0] frame_data;
	logic write_strobe;
	logic [7:0] receiver_status;
	logic fsk_cal_precision, duty_cycled_receive;

	// Pin synchronisers: stage 0 feeds stage 1 only
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs_sync <= 3'h7;
			sclk_sync <= 3'h0;
			sdl_sync <= 3'h0;
			agc_sync <= 3'h0;
			lock_sync <= 2'h0;
			alive_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], cs_n};
			sclk_sync <= {sclk_sync[1:0], sclk};
			sdl_sync <= {sdl_sync[1:0], serial_data_line_in};
			agc_sync <= {agc_sync[1:0], agc_above_threshold};
			lock_sync <= {lock_sync[0], pll_lock};
			alive_sync <= {alive_sync[0], crystal_alive};
		end
	end

	assign cs_n_s = cs_sync[1];
	assign sclk_s = sclk_sync[1];
	assign sdl_s = sdl_sync[1];
	assign agc_s = agc_sync[1];
	assign cs_rise = cs_sync[1] && !cs_sync[2];
	assign cs_fall = !cs_sync[1] && cs_sync[2];
	assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
	assign sclk_fall = !sclk_sync[1] && sclk_sync[2];
	assign frame_cmd = shift_in[15:12];
	assign frame_addr = shift_in[11:8];
	assign frame_data = shift_in[7:0];
	assign write_strobe = cs_rise && bit_count >= 5'(rxc_pkg::FRAME_BITS) && frame_cmd == rxc_pkg::CMD_WRITE;
	assign soft_rst = reset || mreset_hold;
	assign fsk_cal_precision = device_configuration[rxc_pkg::CFG_FSK_PREC];
	assign duty_cycled_receive = device_configuration[rxc_pkg::CFG_DRX];

	always_comb begin
		receiver_status = 8'h00;
		receiver_status[rxc_pkg::ST_LOCK] = lock_sync[1];
		receiver_status[rxc_pkg::ST_AGC] = low_noise_amplifier_high_gain;
		receiver_status[rxc_pkg::ST_CLK_ALIVE] = alive_sync[1];
		receiver_status[rxc_pkg::ST_POLL_DONE] = poll_timer_cal_complete;
		receiver_status[rxc_pkg::ST_FSK_DONE] = fsk_cal_complete;
	end

	function automatic logic [7:0] read_mux(input logic [3:0] a);
		unique case (a)
			rxc_pkg::ADDR_POWER: read_mux = power_enables;
			rxc_pkg::ADDR_CONFIG: read_mux = device_configuration;
			rxc_pkg::ADDR_CONTROL: read_mux = calibration_and_tracking_control;
			rxc_pkg::ADDR_DIVISOR: read_mux = crystal_divisor;
			rxc_pkg::ADDR_SLEEP_HI: read_mux = sleep_interval_high;
			rxc_pkg::ADDR_SLEEP_LO: read_mux = sleep_interval_low;
			rxc_pkg::ADDR_HOST_WAKE: read_mux = host_wake_interval;
			rxc_pkg::ADDR_SETTLE_HI: read_mux = rf_settle_interval_high;
			rxc_pkg::ADDR_SETTLE_LO: read_mux = rf_settle_interval_low;
			rxc_pkg::ADDR_STATUS: read_mux = receiver_status;
			rxc_pkg::ADDR_DWELL: read_mux = gain_hold_duration;
			default: read_mux = 8'h00;
		endcase
	endfunction

	// Frame shifter; commands act when chip select rises
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shift_in <= 16'h0000;
			bit_count <= 5'h00;
			read_pending <= 1'b0;
			read_active <= 1'b0;
			shift_out <= 8'h00;
			mreset_hold <= 1'b0;
		end else begin
			if (!cs_n_s) begin
				mreset_hold <= 1'b0;
			end
			if (cs_fall) begin
				bit_count <= 5'h00;
				read_active <= read_pending;
				read_pending <= 1'b0;
			end else if (!cs_n_s && sclk_rise) begin
				shift_in <= {shift_in[14:0], sdl_s};
				if (bit_count != 5'h1f) begin
					bit_count <= bit_count + 5'h01;
				end
			end
			if (read_active && !cs_n_s && sclk_fall) begin
				shift_out <= {shift_out[6:0], 1'b0};
			end
			if (cs_rise) begin
				read_active <= 1'b0;
				// Codes 0x0 and 0x4 to 0xF and short frames fall through
				if (bit_count >= 5'(rxc_pkg::READ_MIN_BITS) && frame_cmd == rxc_pkg::CMD_READ) begin
					read_pending <= 1'b1;
					shift_out <= read_mux(frame_addr);
				end
				if (bit_count >= 5'(rxc_pkg::READ_MIN_BITS) && frame_cmd == rxc_pkg::CMD_MRESET) begin
					mreset_hold <= 1'b1;
				end
			end
		end
	end

	// Writable registers; held at reset values during a master reset
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			power_enables <= rxc_pkg::RST_POWER;
			device_configuration <= rxc_pkg::RST_CONFIG;
			crystal_divisor <= rxc_pkg::RST_ZERO;
			sleep_interval_high <= rxc_pkg::RST_ZERO;
			sleep_interval_low <= rxc_pkg::RST_ZERO;
			host_wake_interval <= rxc_pkg::RST_ZERO;
			rf_settle_interval_high <= rxc_pkg::RST_ZERO;
			rf_settle_interval_low <= rxc_pkg::RST_ZERO;
			gain_hold_duration <= rxc_pkg::RST_DWELL;
		end else if (write_strobe) begin
			unique case (frame_addr)
				rxc_pkg::ADDR_POWER: power_enables <= frame_data;
				rxc_pkg::ADDR_CONFIG: device_configuration <= frame_data;
				rxc_pkg::ADDR_DIVISOR: crystal_divisor <= frame_data;
				rxc_pkg::ADDR_SLEEP_HI: sleep_interval_high <= frame_data;
				rxc_pkg::ADDR_SLEEP_LO: sleep_interval_low <= frame_data;
				rxc_pkg::ADDR_HOST_WAKE: host_wake_interval <= frame_data;
				rxc_pkg::ADDR_SETTLE_HI: rf_settle_interval_high <= frame_data;
				rxc_pkg::ADDR_SETTLE_LO: rf_settle_interval_low <= frame_data;
				rxc_pkg::ADDR_DWELL: gain_hold_duration <= frame_data;
				default: ;
			endcase
		end
	end

	// Control register: start bits clear themselves on completion
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			calibration_and_tracking_control <= rxc_pkg::RST_CONTROL;
		end else if (write_strobe && frame_addr == rxc_pkg::ADDR_CONTROL) begin
			calibration_and_tracking_control <= frame_data;
		end else begin
			if (poll_done) begin
				calibration_and_tracking_control[rxc_pkg::CTL_POLL_CAL] <= 1'b0;
			end
			if (fsk_done) begin
				calibration_and_tracking_control[rxc_pkg::CTL_FSK_CAL] <= 1'b0;
			end
		end
	end

	// Completion flags; a finish wins over the clear at a new start
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			poll_timer_cal_complete <= 1'b0;
			fsk_cal_complete <= 1'b0;
		end else begin
			if (poll_done) begin
				poll_timer_cal_complete <= 1'b1;
			end else if (!poll_busy && calibration_and_tracking_control[rxc_pkg::CTL_POLL_CAL]) begin
				poll_timer_cal_complete <= 1'b0;
			end
			if (fsk_done) begin
				fsk_cal_complete <= 1'b1;
			end else if (!fsk_busy && calibration_and_tracking_control[rxc_pkg::CTL_FSK_CAL]) begin
				fsk_cal_complete <= 1'b0;
			end
		end
	end

	// Reference divider, one tick per divisor cycles; image reference toggles per tick
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			div_count <= 8'h00;
			ref_tick <= 1'b0;
			image_reject_ref <= 1'b0;
		end else begin
			ref_tick <= 1'b0;
			if (crystal_divisor == 8'h00 || div_count + 8'h01 >= crystal_divisor) begin
				div_count <= 8'h00;
				ref_tick <= crystal_divisor != 8'h00;
			end else begin
				div_count <= div_count + 8'h01;
			end
			if (ref_tick) begin
				image_reject_ref <= !image_reject_ref;
			end
		end
	end

	// Gain hold: count 2^n clocks while below threshold
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			dwell_count <= 32'h0000_0000;
			low_noise_amplifier_high_gain <= 1'b1;
		end else if (agc_s) begin
			dwell_count <= 32'h0000_0000;
			low_noise_amplifier_high_gain <= 1'b0;
		end else if (!low_noise_amplifier_high_gain) begin
			if (dwell_count + 32'h0000_0001 >= (32'h0000_0001 << gain_hold_duration[rxc_pkg::DWELL_BITS-1:0])) begin
				low_noise_amplifier_high_gain <= 1'b1;
			end
			dwell_count <= dwell_count + 32'h0000_0001;
		end
	end

	rxc_cal_engine #(
		.SHORT_TICKS(rxc_pkg::POLL_CAL_TICKS),
		.LONG_TICKS(rxc_pkg::POLL_CAL_TICKS)
	) poll_cal (
		.core_clk(core_clk),
		.reset(soft_rst),
		.run(calibration_and_tracking_control[rxc_pkg::CTL_POLL_CAL] || auto_cal),
		.long_sel(1'b1),
		.ref_tick(ref_tick),
		.busy(poll_busy),
		.done(poll_done)
	);

	rxc_cal_engine #(
		.SHORT_TICKS(rxc_pkg::FSK_CAL_FAST_TICKS),
		.LONG_TICKS(rxc_pkg::FSK_CAL_FULL_TICKS)
	) fsk_cal (
		.core_clk(core_clk),
		.reset(soft_rst),
		.run(calibration_and_tracking_control[rxc_pkg::CTL_FSK_CAL] || (auto_cal && power_enables[rxc_pkg::PWR_FSK_BB])),
		.long_sel(fsk_cal_precision),
		.ref_tick(ref_tick),
		.busy(fsk_busy),
		.done(fsk_done)
	);

	// Duty-cycled wake sequencer: sleep, host wake, RF settle, active
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			seq_state <= SEQ_IDLE;
			unit_count <= 16'h0000;
			base_count <= 16'h0000;
			seq_target <= 16'h0000;
			base_target <= 16'h0000;
			own_pull_hist <= 3'h0;
			host_held <= 1'b0;
			seq_drive_low <= 1'b0;
			auto_cal <= 1'b0;
			rf_sections_on <= 1'b0;
			peak_detectors_on <= 1'b0;
			data_outputs_on <= 1'b0;
		end else begin
			auto_cal <= 1'b0;
			own_pull_hist <= {own_pull_hist[1:0], !serial_data_line_drive_n};
			if (ref_tick && seq_state != SEQ_IDLE && seq_state != SEQ_ACTIVE) begin
				if (base_count + 16'h0001 >= base_target) begin
					base_count <= 16'h0000;
					unit_count <= unit_count + 16'h0001;
				end else begin
					base_count <= base_count + 16'h0001;
				end
			end
			if (!duty_cycled_receive || !cs_n_s) begin
				seq_state <= SEQ_IDLE;
				seq_drive_low <= 1'b0;
				rf_sections_on <= !duty_cycled_receive;
				peak_detectors_on <= !duty_cycled_receive;
				data_outputs_on <= !duty_cycled_receive;
			end else begin
				unique case (seq_state)
					SEQ_IDLE: begin
						if (sdl_s) begin
							seq_state <= SEQ_SLEEP;
							unit_count <= 16'h0000;
							base_count <= 16'h0000;
							seq_target <= {sleep_interval_high, sleep_interval_low};
							unique case (device_configuration[rxc_pkg::CFG_PS_LO +: 2])
								2'h0: base_target <= 16'(rxc_pkg::SLEEP_BASE_0);
								2'h1: base_target <= 16'(rxc_pkg::SLEEP_BASE_1);
								2'h2: base_target <= 16'(rxc_pkg::SLEEP_BASE_2);
								2'h3: base_target <= 16'(rxc_pkg::SLEEP_BASE_3);
							endcase
							rf_sections_on <= 1'b0;
							peak_detectors_on <= 1'b0;
							data_outputs_on <= 1'b0;
						end
					end
					SEQ_SLEEP: begin
						if (unit_count >= seq_target) begin
							seq_state <= SEQ_HOST_WAKE;
							seq_drive_low <= 1'b1;
							auto_cal <= 1'b1;
							unit_count <= 16'h0000;
							base_count <= 16'h0000;
							base_target <= 16'(rxc_pkg::HOST_WAKE_TICKS);
							seq_target <= {8'h00, host_wake_interval};
						end
					end
					SEQ_HOST_WAKE: begin
						if (unit_count >= seq_target) begin
							seq_state <= SEQ_SETTLE;
							seq_drive_low <= 1'b0;
							host_held <= 1'b0;
							unit_count <= 16'h0000;
							base_count <= 16'h0000;
							base_target <= 16'h0001;
							seq_target <= {rf_settle_interval_high, rf_settle_interval_low};
							rf_sections_on <= 1'b1;
						end
					end
					SEQ_SETTLE: begin
						// Own wake pull must leave the synchroniser before a low counts as the host
						if (!sdl_s && own_pull_hist == 3'h0) begin
							host_held <= 1'b1;
						end
						if (unit_count >= seq_target) begin
							if (host_held || (!sdl_s && own_pull_hist == 3'h0)) begin
								seq_state <= SEQ_ACTIVE;
								peak_detectors_on <= 1'b1;
								data_outputs_on <= 1'b1;
							end else begin
								seq_state <= SEQ_IDLE;
								rf_sections_on <= 1'b0;
							end
						end
					end
					SEQ_ACTIVE: begin
						if (sdl_s) begin
							seq_state <= SEQ_IDLE;
							rf_sections_on <= 1'b0;
							peak_detectors_on <= 1'b0;
							data_outputs_on <= 1'b0;
						end
					end
					default: seq_state <= SEQ_IDLE;
				endcase
			end
		end
	end

	// Line driver: read data during the frame after a read, wake pull-low otherwise
	always_ff @(posedge core_clk) begin
		if (reset) begin
			serial_data_line_out <= 1'b0;
			serial_data_line_drive_n <= 1'b1;
		end else if (read_active && !cs_n_s) begin
			serial_data_line_out <= shift_out[7];
			serial_data_line_drive_n <= 1'b0;
		end else begin
			serial_data_line_out <= 1'b0;
			serial_data_line_drive_n <= !seq_drive_low;
		end
	end
endmodule

// ### rxc_core_properties.sv
`timescale 1ns/1ps
module rxc_core_props (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic serial_data_line_drive_n,
	input wire logic agc_above_threshold,
	input wire logic [7:0] power_enables,
	input wire logic [7:0] device_configuration,
	input wire logic [7:0] calibration_and_tracking_control,
	input wire logic low_noise_amplifier_high_gain,
	input wire logic image_reject_ref,
	input wire logic rf_sections_on,
	input wire logic peak_detectors_on,
	input wire logic data_outputs_on
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	reset_state_a: assert property (disable iff (1'b0) reset |=> device_configuration == 8'h40 &&
		power_enables == 8'h00 && serial_data_line_drive_n && !image_reject_ref) else $error("bad reset state");
	read_cs_a: assert property ($fell(serial_data_line_drive_n) |-> !cs_n || device_configuration[0])
		else $error("drive while deselected");
	read_release_a: assert property ($rose(cs_n) |-> ##[0:5] serial_data_line_drive_n) else $error("no release");
	gain_drop_a: assert property ($rose(agc_above_threshold) |-> ##[1:4] !low_noise_amplifier_high_gain)
		else $error("gain not lowered");
	gain_hold_a: assert property (agc_above_threshold [*4] |-> !low_noise_amplifier_high_gain)
		else $error("high gain while power high");
	gain_return_a: assert property ($rose(low_noise_amplifier_high_gain) |-> !$past(agc_above_threshold, 3))
		else $error("gain raised early");
	settle_out_a: assert property (peak_detectors_on || data_outputs_on |-> rf_sections_on)
		else $error("outputs without rf");
	peak_order_a: assert property ($rose(peak_detectors_on) && device_configuration[0] |-> $past(rf_sections_on))
		else $error("peak before settle");
	write_window_a: assert property (!$stable(power_enables) || !$stable(device_configuration) |-> cs_n)
		else $error("register change in frame");
	cal_start_a: assert property ($rose(calibration_and_tracking_control[1]) |-> cs_n)
		else $error("start bit set in frame");

	cover property ($fell(calibration_and_tracking_control[1]));
	cover property ($rose(low_noise_amplifier_high_gain));
	cover property ($fell(serial_data_line_drive_n));
	cover property ($rose(data_outputs_on));
endmodule

bind rxc_core rxc_core_props u_rxc_core_props (.core_clk, .reset, .cs_n, .serial_data_line_drive_n,
	.agc_above_threshold, .power_enables, .device_configuration, .calibration_and_tracking_control,
	.low_noise_amplifier_high_gain, .image_reject_ref, .rf_sections_on, .peak_detectors_on, .data_outputs_on);

// ### rxc_host_model.sv
`timescale 1ns/1ps
module rxc_host_model (
	input wire logic core_clk,
	input wire logic line,
	output logic cs_n = 1'b1,
	output logic sclk = 1'b0,
	output logic host_oe = 1'b1,
	output logic host_val = 1'b0,
	output logic rd_valid = 1'b0,
	output logic [7:0] rd_data = 8'h00
);
	int hp = 6;

	task automatic xfer(input logic [15:0] w);
		int i;
		@(posedge core_clk) cs_n <= 1'b0;
		host_oe <= 1'b1;
		repeat (hp) @(posedge core_clk);
		for (i = 15; i >= 0; i--) begin
			host_val <= w[i];
			repeat (hp) @(posedge core_clk);
			sclk <= 1'b1;
			repeat (hp) @(posedge core_clk);
			sclk <= 1'b0;
		end
		repeat (hp) @(posedge core_clk);
		cs_n <= 1'b1;
		host_val <= 1'b0;
		repeat (hp) @(posedge core_clk);
	endtask

	// Answer slot after a read command, line left to the device
	task automatic rx();
		int i;
		@(posedge core_clk) cs_n <= 1'b0;
		host_oe <= 1'b0;
		for (i = 7; i >= 0; i--) begin
			repeat (8) @(posedge core_clk);
			rd_data[i] <= line;
			sclk <= 1'b1;
			repeat (8) @(posedge core_clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge core_clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		host_oe <= 1'b1;
		rd_valid <= 1'b1;
		@(posedge core_clk) rd_valid <= 1'b0;
	endtask

	// Release the line, wait for the wake pull and its release, then answer low
	task automatic wake(output logic ok, input logic answer);
		int i;
		@(posedge core_clk) host_oe <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < 4000 && line !== 1'b0; i++) @(posedge core_clk);
		for (i = 0; i < 4000 && line !== 1'b1; i++) @(posedge core_clk);
		ok = line === 1'b1;
		if (answer) begin
			host_oe <= 1'b1;
		end
	endtask
endmodule

// ### rx_control_regs_calibration_tb.sv
`timescale 1ns/1ps
module rx_control_regs_calibration_tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic agc = 1'b0;
	logic lock = 1'b0;
	logic alive = 1'b0;
	logic cs_n, sclk, host_oe, host_val, rd_valid, d_out, d_drv_n, hg, iref, rf_on, pk_on, dat_on, ok;
	logic [7:0] rd_data, pwr, cfg, ctl, st, v;
	logic [1:0] flags;
	logic [31:0] seed = 32'd38369;
	logic [7:0] exp_q[$];
	int failures = 0;
	int checks_done = 0;
	int i, k, n;
	time t0;
	wire line = !d_drv_n ? d_out : host_oe ? host_val : 1'b1;

	always #20 core_clk = ~core_clk;

	rxc_core u_rxc_core (.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
		.serial_data_line_in(line), .serial_data_line_out(d_out), .serial_data_line_drive_n(d_drv_n),
		.agc_above_threshold(agc), .pll_lock(lock), .crystal_alive(alive), .power_enables(pwr),
		.device_configuration(cfg), .calibration_and_tracking_control(ctl),
		.low_noise_amplifier_high_gain(hg), .image_reject_ref(iref), .rf_sections_on(rf_on),
		.peak_detectors_on(pk_on), .data_outputs_on(dat_on));
	rxc_host_model u_rxc_host_model (.core_clk(core_clk), .line(line), .cs_n(cs_n), .sclk(sclk),
		.host_oe(host_oe), .host_val(host_val), .rd_valid(rd_valid), .rd_data(rd_data));

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic stop_test();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_rxc_host_model.xfer({rxc_pkg::CMD_WRITE, a, d});
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_rxc_host_model.xfer({rxc_pkg::CMD_READ, a, 8'h00});
		u_rxc_host_model.rx();
	endtask

	always @(posedge rd_valid) check("read", rd_data, exp_q.pop_front());

	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		stop_test();
	end

	initial begin
		v = rnd();
		lock <= v[0];
		alive <= v[1];
		st = {v[0], 1'b1, v[1], 5'h00};
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		repeat (5) @(posedge core_clk);
		// Every location, slow and fast host, status and unmapped included
		for (i = 0; i < 16; i++) begin
			v = rnd() & (i == 1 ? 8'hfe : i == 2 ? 8'hfc : i == 10 ? 8'h1f : 8'hff);
			u_rxc_host_model.hp = 3 + i % 4;
			wr(i[3:0], v);
			rd(i[3:0], i == 9 ? st : i > 10 ? 8'h00 : v);
		end
		wr(rxc_pkg::ADDR_POWER, 8'h5a);
		for (i = 0; i < 16; i++) begin
			if (i == 0 || i > 3)
				u_rxc_host_model.xfer({i[3:0], rxc_pkg::ADDR_POWER, 8'ha5});
		end
		rd(rxc_pkg::ADDR_POWER, 8'h5a);
		u_rxc_host_model.xfer({rxc_pkg::CMD_MRESET, 4'h0, 8'h00});
		repeat (20) @(posedge core_clk);
		check("held_cfg", cfg, rxc_pkg::RST_CONFIG);
		check("held_pwr", pwr, 8'h00);
		rd(rxc_pkg::ADDR_DWELL, 8'h0d);
		rd(rxc_pkg::ADDR_STATUS, st);
		wr(rxc_pkg::ADDR_DIVISOR, 8'h05);
		wr(rxc_pkg::ADDR_POWER, 8'h20);
		@(iref);
		t0 = $time;
		@(iref);
		check("ref_period", 8'(($time - t0) / 40), 8'h05);
		flags = 2'b00;
		for (i = 0; i < 3; i++) begin
			wr(rxc_pkg::ADDR_CONFIG, i == 2 ? 8'h60 : 8'h40);
			wr(rxc_pkg::ADDR_CONTROL, i == 0 ? 8'h02 : 8'h01);
			n = i == 0 ? 256 : i == 1 ? 64 : 512;
			for (k = 0; k < 5000 && ctl[i == 0 ? 1 : 0] !== 1'b0; k++) @(posedge core_clk);
			check("cal_time", 8'(k >= (n - 1) * 5 - 10 && k <= n * 5 + 4), 8'h01);
			flags = flags | (i == 0 ? 2'b10 : 2'b01);
			rd(rxc_pkg::ADDR_STATUS, {st[7:2], flags});
		end
		wr(rxc_pkg::ADDR_DWELL, 8'h04);
		@(posedge core_clk) agc <= 1'b1;
		repeat (10) @(posedge core_clk);
		check("gain_low", {7'h00, hg}, 8'h00);
		agc <= 1'b0;
		for (k = 0; k < 200 && hg !== 1'b1; k++) @(posedge core_clk);
		check("dwell_time", 8'(k >= 16 && k <= 22), 8'h01);
		wr(rxc_pkg::ADDR_SLEEP_LO, 8'h01);
		wr(rxc_pkg::ADDR_HOST_WAKE, 8'h01);
		wr(rxc_pkg::ADDR_SETTLE_LO, 8'h10);
		wr(rxc_pkg::ADDR_CONFIG, 8'h41);
		u_rxc_host_model.wake(ok, 1'b1);
		check("settle", {4'h0, ok, rf_on, pk_on, dat_on}, 8'h0c);
		for (k = 0; k < 500 && dat_on !== 1'b1; k++) @(posedge core_clk);
		check("active", {6'h00, pk_on, dat_on}, 8'h03);
		// Silent host: settle times out and the wake cycle restarts
		u_rxc_host_model.wake(ok, 1'b0);
		n = 0;
		for (k = 0; k < 100; k++) @(posedge core_clk) n = n | pk_on | dat_on;
		check("no_answer", {6'h00, n[0], rf_on}, 8'h00);
		u_rxc_host_model.wake(ok, 1'b1);
		check("rewake", {7'h00, ok}, 8'h01);
		wr(rxc_pkg::ADDR_CONFIG, 8'h40);
		stop_test();
	end
endmodule
